//--- src/sms_pkg.sv
// Constants for the compact store decoder and sequencer.
// Assumes a 64-bit general register file with 32 entries.
package sms_pkg;
    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    localparam logic [5:0] SMS_OP_STACK_WORD = 6'h32;
    localparam logic [5:0] SMS_OP_GROUP_C = 6'h11;
    localparam logic [3:0] SMS_MINOR_SHORT = 4'hA;
    localparam logic [5:0] SMS_OP_GROUP_B = 6'h08;
    localparam logic [3:0] SMS_MINOR_LONG = 4'hD;
    // ----------------------------------------
    // Register numbers and the list code that adds fp
    // ----------------------------------------
    localparam logic [4:0] SMS_REG_SP = 5'h1D;
    localparam logic [4:0] SMS_REG_S0 = 5'h10;
    localparam logic [4:0] SMS_REG_FP = 5'h1E;
    localparam logic [4:0] SMS_REG_RA = 5'h1F;
    localparam logic [3:0] SMS_LIST_FP = 4'h9;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int SMS_AW = 64;
    localparam int SMS_DW = 32;
    localparam int SMS_FIFO_DEPTH = 16;
    localparam logic [63:0] SMS_WORD_STEP = 64'h4;
    localparam logic [1:0] SMS_ALIGNED = 2'h0;
    // ----------------------------------------
    // Exception codes
    // ----------------------------------------
    localparam logic [2:0] SMS_EXC_TLB_REFILL = 3'h0;
    localparam logic [2:0] SMS_EXC_TLB_INVALID = 3'h1;
    localparam logic [2:0] SMS_EXC_TLB_MODIFIED = 3'h2;
    localparam logic [2:0] SMS_EXC_ADDR = 3'h3;
    localparam logic [2:0] SMS_EXC_WATCH = 3'h4;
    localparam logic [2:0] SMS_EXC_RESERVED = 3'h5;
    typedef enum logic [1:0] {SMS_IDLE = 2'h0, SMS_BASE = 2'h1, SMS_STORE = 2'h3} sms_state_e;
    typedef enum logic [1:0] {SMS_K_STACK = 2'h0, SMS_K_SHORT = 2'h1, SMS_K_LONG = 2'h2} sms_kind_e;
endpackage : sms_pkg

//--- src/sms_store_seq.sv
// Store decoder/sequencer for the stack word store and two multi-word stores.
// Assumes a combinational register read port and a store path behind a FIFO.
`timescale 1ns/1ps
`default_nettype none

module sms_fifo #(
    parameter int WIDTH = 96,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic wr_en, rd_en;

    assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {PW{1'b0}}};
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[PW-1:0]];
    assign wr_en = in_valid && in_ready;
    assign rd_en = out_valid && out_ready;

    always_comb
    begin
        next_wr_ptr = wr_ptr + {{PW{1'b0}}, wr_en};
        next_rd_ptr = rd_ptr + {{PW{1'b0}}, rd_en};
        if (flush)
        begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge clock)
    begin
        if (wr_en)
            mem[wr_ptr[PW-1:0]] <= in_data;
    end
endmodule : sms_fifo

module sms_store_seq
    import sms_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Instruction in; 16-bit forms sit in bits 15..0
    input wire logic instr_valid,
    output logic instr_ready,
    input wire logic [31:0] instr,
    input wire logic instr_is_16,
    input wire logic misalign_ok,
    output logic instr_done,
    output logic instr_miss,
    // Register read port
    output logic [4:0] gpr_rd_addr,
    input wire logic [63:0] gpr_rd_data,
    // Store stream to translation and memory
    output logic st_valid,
    input wire logic st_ready,
    output logic [SMS_AW-1:0] st_addr,
    output logic [SMS_DW-1:0] st_data,
    // Faults from translation and checking
    input wire logic mem_fault,
    input wire logic [2:0] mem_fault_code,
    // Exception out
    output logic exc_valid,
    output logic [2:0] exc_code
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic is_stack, is_short, is_long, take, list_bad;
    logic [3:0] n16_d, total_d;
    assign is_stack = instr_is_16 && instr[15:10] == SMS_OP_STACK_WORD;
    assign is_short = instr_is_16 && instr[15:10] == SMS_OP_GROUP_C
        && instr[3:0] == SMS_MINOR_SHORT;
    assign is_long = !instr_is_16 && instr[31:26] == SMS_OP_GROUP_B
        && instr[15:12] == SMS_MINOR_LONG;
    // Codes above 9 in the low bits, and all zero, name no list
    assign list_bad = instr[24:21] > SMS_LIST_FP || instr[25:21] == 5'h00;

    sms_state_e state, next_state;
    sms_kind_e kind, next_kind;
    logic [4:0] src, next_src, base, next_base;
    logic [63:0] off, next_off, addr, next_addr;
    logic [3:0] idx, next_idx, n16, next_n16, total, next_total;
    logic fp, next_fp;
    logic next_exc_valid, next_done, next_miss;
    logic [2:0] next_exc_code;
    logic push, last, fifo_in_ready;

    assign instr_ready = state == SMS_IDLE;
    assign take = instr_valid && instr_ready;
    assign n16_d = is_short ? {2'h0, instr[9:8]} + 4'h1
        : (instr[24:21] == SMS_LIST_FP ? 4'h8 : instr[24:21]);
    assign total_d = is_stack ? 4'h1 : n16_d + {3'h0, is_long && instr[24:21] == SMS_LIST_FP}
        + {3'h0, is_short || instr[25]};
    assign last = idx == total - 4'h1;
    assign push = state == SMS_STORE && !mem_fault;

    // ----------------------------------------
    // Register selection
    // ----------------------------------------
    always_comb
    begin
        gpr_rd_addr = base;
        if (state == SMS_STORE)
        begin
            if (kind == SMS_K_STACK)
                gpr_rd_addr = src;
            else if (idx < n16)
                gpr_rd_addr = SMS_REG_S0 + {1'b0, idx};
            else if (fp && idx == n16)
                gpr_rd_addr = SMS_REG_FP;
            else
                gpr_rd_addr = SMS_REG_RA;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        next_kind = kind;
        next_src = src;
        next_base = base;
        next_off = off;
        next_addr = addr;
        next_idx = idx;
        next_n16 = n16;
        next_total = total;
        next_fp = fp;
        next_exc_valid = 1'b0;
        next_exc_code = exc_code;
        next_done = 1'b0;
        next_miss = 1'b0;
        case (state)
            SMS_IDLE:
            begin
                if (take)
                begin
                    next_idx = '0;
                    next_n16 = n16_d;
                    next_total = total_d;
                    next_fp = is_long && instr[24:21] == SMS_LIST_FP;
                    next_src = instr[9:5];
                    next_base = is_long ? instr[20:16] : SMS_REG_SP;
                    next_state = SMS_BASE;
                    if (is_stack)
                    begin
                        next_kind = SMS_K_STACK;
                        next_off = {57'h0, instr[4:0], 2'h0};
                    end
                    else if (is_short)
                    begin
                        next_kind = SMS_K_SHORT;
                        next_off = {58'h0, instr[7:4], 2'h0};
                    end
                    else if (is_long && !list_bad)
                    begin
                        next_kind = SMS_K_LONG;
                        next_off = {{52{instr[11]}}, instr[11:0]};
                    end
                    else
                    begin
                        next_state = SMS_IDLE;
                        next_exc_valid = is_long;
                        next_exc_code = SMS_EXC_RESERVED;
                        next_miss = !is_long;
                    end
                end
            end
            SMS_BASE:
            begin
                next_addr = gpr_rd_data + off;
                next_state = SMS_STORE;
                if (next_addr[1:0] != SMS_ALIGNED && !(kind == SMS_K_LONG && misalign_ok))
                begin
                    next_state = SMS_IDLE;
                    next_exc_valid = 1'b1;
                    next_exc_code = SMS_EXC_ADDR;
                end
            end
            SMS_STORE:
            begin
                if (mem_fault)
                begin
                    // Abandon the sequence; software restarts it from the first word
                    next_state = SMS_IDLE;
                    next_exc_valid = 1'b1;
                    next_exc_code = mem_fault_code;
                end
                else if (fifo_in_ready)
                begin
                    next_addr = addr + SMS_WORD_STEP;
                    next_idx = idx + 4'h1;
                    if (last)
                    begin
                        next_state = SMS_IDLE;
                        next_done = 1'b1;
                    end
                end
            end
            default: next_state = SMS_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= SMS_IDLE;
            kind <= SMS_K_STACK;
            src <= '0;
            base <= '0;
            off <= '0;
            addr <= '0;
            idx <= '0;
            n16 <= '0;
            total <= '0;
            fp <= 1'b0;
            exc_valid <= 1'b0;
            exc_code <= SMS_EXC_TLB_REFILL;
            instr_done <= 1'b0;
            instr_miss <= 1'b0;
        end
        else
        begin
            state <= next_state;
            kind <= next_kind;
            src <= next_src;
            base <= next_base;
            off <= next_off;
            addr <= next_addr;
            idx <= next_idx;
            n16 <= next_n16;
            total <= next_total;
            fp <= next_fp;
            exc_valid <= next_exc_valid;
            exc_code <= next_exc_code;
            instr_done <= next_done;
            instr_miss <= next_miss;
        end
    end

    // ----------------------------------------
    // Store FIFO
    // ----------------------------------------
    logic [SMS_AW+SMS_DW-1:0] fifo_out;
    sms_fifo #(.WIDTH(SMS_AW + SMS_DW), .DEPTH(SMS_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .flush(state == SMS_STORE && mem_fault),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data({addr, gpr_rd_data[SMS_DW-1:0]}),
        .out_valid(st_valid),
        .out_ready(st_ready),
        .out_data(fifo_out)
    );
    assign st_addr = fifo_out[SMS_AW+SMS_DW-1:SMS_DW];
    assign st_data = fifo_out[SMS_DW-1:0];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    stack_decode_a: assert property (take && is_stack |=> state == SMS_BASE && base == SMS_REG_SP)
        else $error("stack store not decoded");
    stack_ea_a: assert property (state == SMS_BASE && kind == SMS_K_STACK |=>
        addr == $past(gpr_rd_data) + {57'h0, $past(off[6:2]), 2'h0})
        else $error("stack address wrong");
    low_word_a: assert property (push && fifo_in_ready && !st_valid |=> st_valid
        && st_data == $past(gpr_rd_data[SMS_DW-1:0]) && st_addr == $past(addr))
        else $error("stored word not low half");
    align_err_a: assert property (state == SMS_BASE && kind != SMS_K_LONG && next_addr[1:0] != 2'h0
        |=> exc_valid && exc_code == SMS_EXC_ADDR && state == SMS_IDLE)
        else $error("misaligned start not refused");
    fault_pass_a: assert property (state == SMS_STORE && mem_fault |=> exc_valid
        && exc_code == $past(mem_fault_code) && !st_valid && instr_ready)
        else $error("fault not reported");
    short_count_a: assert property (take && is_short && instr[9:8] == 2'h0 |=> total == 4'h2)
        else $error("short list count wrong");
    short_ra_a: assert property (state == SMS_STORE && kind == SMS_K_SHORT && last
        |-> gpr_rd_addr == SMS_REG_RA)
        else $error("short list does not end at 31");
    addr_step_a: assert property (push && fifo_in_ready && !last |=> addr == $past(addr) + 64'h4)
        else $error("address did not advance by four");
    reserved_a: assert property (take && is_long && list_bad |=> exc_valid
        && exc_code == SMS_EXC_RESERVED && state == SMS_IDLE)
        else $error("reserved list accepted");
    long_fp_a: assert property (take && is_long && instr[25:21] == 5'h09 |=> total == 4'h9 && fp)
        else $error("list nine wrong");
endmodule : sms_store_seq

`default_nettype wire

//--- test/sms_mem_model.sv
// Stand-in for the register file and the store path behind the sequencer.
// Assumes the bench drives stall, slow and sp_value at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module sms_mem_model
    import sms_pkg::*;
(
    // Clock
    input wire logic clock,
    // Bench control
    input wire logic stall,
    input wire logic slow,
    input wire logic [63:0] sp_value,
    // Register read port
    input wire logic [4:0] gpr_rd_addr,
    output logic [63:0] gpr_rd_data,
    // Store stream
    input wire logic st_valid,
    output logic st_ready,
    input wire logic [SMS_AW-1:0] st_addr,
    input wire logic [SMS_DW-1:0] st_data
);
    // ----------------------------------------
    // Register file and acceptor
    // ----------------------------------------
    logic phase = 1'b0;
    int n_seen = 0;
    logic [SMS_AW-1:0] log_addr [0:511];
    logic [SMS_DW-1:0] log_data [0:511];
    // Upper half all ones for every register but sp, so storing the wrong half is caught
    assign gpr_rd_data = (gpr_rd_addr == SMS_REG_SP) ? sp_value :
        {32'hFFFFFFFF, 27'h5A00000, gpr_rd_addr};
    // Slow mode takes a word only every other cycle
    assign st_ready = !stall && (!slow || phase);
    always @(posedge clock)
    begin
        phase <= !phase;
        if (st_valid && st_ready)
        begin
            log_addr[n_seen] <= st_addr;
            log_data[n_seen] <= st_data;
            n_seen <= n_seen + 1;
        end
    end
endmodule : sms_mem_model
`default_nettype wire

//--- test/stack_and_multi_word_store_tb.sv
// Self-checking bench for the store sequencer.
// Assumes sms_pkg, the design and sms_mem_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module stack_and_multi_word_store_tb
    import sms_pkg::*;
;
    logic clock = 0, rst_n = 0, instr_valid = 0, instr_is_16 = 0, misalign_ok = 0;
    logic instr_ready, instr_done, instr_miss, st_valid, st_ready, exc_valid;
    logic mem_fault = 0, stall = 0, slow = 0;
    logic [31:0] instr = 32'h0;
    logic [4:0] gpr_rd_addr;
    logic [63:0] gpr_rd_data, sp = 64'h1000;
    logic [SMS_AW-1:0] st_addr;
    logic [SMS_DW-1:0] st_data;
    logic [2:0] exc_code, mem_fault_code = 3'h0;
    logic [4:0] regs [$];
    int mismatches = 0, checks = 0, exp_idx = 0, cycles = 0;

    sms_store_seq dut (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .instr(instr), .instr_is_16(instr_is_16),
        .misalign_ok(misalign_ok), .instr_done(instr_done), .instr_miss(instr_miss),
        .gpr_rd_addr(gpr_rd_addr), .gpr_rd_data(gpr_rd_data), .st_valid(st_valid),
        .st_ready(st_ready), .st_addr(st_addr), .st_data(st_data), .mem_fault(mem_fault),
        .mem_fault_code(mem_fault_code), .exc_valid(exc_valid), .exc_code(exc_code));
    sms_mem_model mem (.clock(clock), .stall(stall), .slow(slow), .sp_value(sp),
        .gpr_rd_addr(gpr_rd_addr), .gpr_rd_data(gpr_rd_data), .st_valid(st_valid),
        .st_ready(st_ready), .st_addr(st_addr), .st_data(st_data));

    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    initial forever #12.5 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    task check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    function automatic logic [31:0] lw(input logic [4:0] c, input logic [11:0] o);
        return {SMS_OP_GROUP_B, c, SMS_REG_SP, SMS_MINOR_LONG, o};
    endfunction : lw
    // Result: 8 done, 9 ignored, otherwise the exception code
    task issue(input logic [31:0] w, input logic s16, input logic mo, output int r);
        int k;
        k = 0;
        @(negedge clock);
        while (instr_ready !== 1'b1 && k < 200)
        begin
            @(negedge clock);
            k++;
        end
        instr = w;
        instr_is_16 = s16;
        misalign_ok = mo;
        instr_valid = 1'b1;
        r = -1;
        // Result pulses stand one cycle, the first one right after the take
        for (k = 0; k < 300 && r < 0; k++)
        begin
            @(negedge clock);
            instr_valid = 1'b0;
            if (instr_done === 1'b1)
                r = 8;
            else if (instr_miss === 1'b1)
                r = 9;
            else if (exc_valid === 1'b1)
                r = $isunknown(exc_code) ? 99 : int'(exc_code);
        end
    endtask : issue
    task expect_words(input logic [63:0] start);
        int k;
        for (int i = 0; i < regs.size(); i++)
        begin
            k = 0;
            while (mem.n_seen <= exp_idx && k < 200)
            begin
                @(negedge clock);
                k++;
            end
            check(mem.log_addr[exp_idx], start + 64'(4 * i));
            check(64'(mem.log_data[exp_idx]), {32'h0, 27'h5A00000, regs[i]});
            exp_idx++;
        end
    endtask : expect_words
    task long_list(input logic [4:0] c);
        regs = '{};
        for (int i = 0; i < 8 && i < c[3:0]; i++)
            regs.push_back(SMS_REG_S0 + 5'(i));
        if (c[3:0] == SMS_LIST_FP)
            regs.push_back(SMS_REG_FP);
        if (c[4])
            regs.push_back(SMS_REG_RA);
    endtask : long_list

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_stack;
        int r;
        regs = '{5'h07};
        issue({16'h0, SMS_OP_STACK_WORD, 5'h07, 5'h1F}, 1'b1, 1'b0, r);
        check(64'(r), 64'h8);
        expect_words(sp + 64'h7C);
        sp = 64'h1002;
        issue({16'h0, SMS_OP_STACK_WORD, 5'h07, 5'h1F}, 1'b1, 1'b0, r);
        check(64'(r), 64'(SMS_EXC_ADDR));
        sp = 64'h1000;
    endtask : t_stack
    task t_short;
        int r;
        for (int c = 0; c < 4; c++)
        begin
            regs = '{};
            for (int i = 0; i <= c; i++)
                regs.push_back(SMS_REG_S0 + 5'(i));
            regs.push_back(SMS_REG_RA);
            issue({16'h0, SMS_OP_GROUP_C, 2'(c), 4'hF, SMS_MINOR_SHORT}, 1'b1, 1'b0, r);
            check(64'(r), 64'h8);
            expect_words(sp + 64'h3C);
        end
        sp = 64'h1001;
        issue({16'h0, SMS_OP_GROUP_C, 2'h3, 4'h0, SMS_MINOR_SHORT}, 1'b1, 1'b0, r);
        check(64'(r), 64'(SMS_EXC_ADDR));
        sp = 64'h1000;
    endtask : t_short
    task t_long;
        int r;
        slow = 1'b1;
        for (int c = 0; c < 32; c++)
        begin
            long_list(5'(c));
            issue(lw(5'(c), 12'hFFC), 1'b0, 1'b0, r);
            if (regs.size() == 0 || c[3:0] > 9)
                check(64'(r), 64'(SMS_EXC_RESERVED));
            else
            begin
                check(64'(r), 64'h8);
                expect_words(sp - 64'h4);
            end
        end
        slow = 1'b0;
        long_list(5'h19);
        issue(lw(5'h19, 12'h002), 1'b0, 1'b0, r);
        check(64'(r), 64'(SMS_EXC_ADDR));
        issue(lw(5'h19, 12'h002), 1'b0, 1'b1, r);
        check(64'(r), 64'h8);
        expect_words(sp + 64'h2);
        issue(32'h0, 1'b0, 1'b0, r);
        check(64'(r), 64'h9);
    endtask : t_long
    task t_fault;
        int r;
        stall = 1'b1;
        for (int f = 0; f < 5; f++)
        begin
            fork
                issue(lw(5'h19, 12'h000), 1'b0, 1'b0, r);
                begin
                    repeat (3) @(negedge clock);
                    mem_fault = 1'b1;
                    mem_fault_code = 3'(f);
                    @(negedge clock);
                    mem_fault = 1'b0;
                end
            join
            check(64'(r), 64'(f));
        end
        stall = 1'b0;
        repeat (20) @(negedge clock);
        check(64'(mem.n_seen), 64'(exp_idx));
    endtask : t_fault
    task t_fill;
        int r;
        long_list(5'h19);
        stall = 1'b1;
        issue(lw(5'h19, 12'h000), 1'b0, 1'b0, r);
        check(64'(r), 64'h8);
        fork
            issue(lw(5'h19, 12'h028), 1'b0, 1'b0, r);
            begin
                // Twenty words against sixteen places: the sequencer must hold
                repeat (40) @(negedge clock);
                check(64'(instr_ready), 64'h0);
                check(64'(st_valid), 64'h1);
                stall = 1'b0;
            end
        join
        check(64'(r), 64'h8);
        expect_words(sp);
        expect_words(sp + 64'h28);
    endtask : t_fill

    initial
    begin
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        t_stack();
        t_short();
        t_long();
        t_fault();
        t_fill();
        repeat (20) @(negedge clock);
        check(64'(mem.n_seen), 64'(exp_idx));
        end_of_test();
    end
endmodule : stack_and_multi_word_store_tb
`default_nettype wire
